// File: verilog/irm_mode_control.sv
/*
 * Infrared mode control: the interface select and operating control
 * registers on the peripheral bus, transmit done status, receive and
 * transmit enables, address filtering and the pin paths.
 * Assumes an APB master on MCLK, encoders and decoders on MCLK, and a
 * pin sharing select from a system register on the same clock.
 */
// Summary of operation
// [R1] Sharing off: UART only; on: OR of outputs
// [R2] Receive path always reads the receive pin
// [R3] Software sets sharing before any infrared mode
// [R4] Mode field: none, low, medium, fast
// [R5] Medium and fast share control, separate status
// [R6] Bit 4 reports fast transmitter done
// [R7] Bit 3 reports medium transmitter done
// [R8] Done low while enabled, high after disable
// [R9] Software polls busy before clearing transmit enable
// [R10] Loopback feeds transmit shifter into receive shifter
// [R11] Software clears both enables before mode change
// [R12] Control writes take effect while active
// [R13] Address filter: match or broadcast, else all
// [R14] Receive polarity inverts input before decoding
// [R15] Transmit polarity inverts output before pin
// [R16] Receive enable starts and stops receive logic
// [R17] Transmit enable starts and stops transmit logic
// [R18] Underrun sends CRC and stop, or abort
// [R19] Rate bit selects 0.576 or 1.152 Mbit/s
// [R20] Software writes zero to control bit 0
// [R21] Read-only and reserved bits ignore writes
`timescale 1ns/1ps
module irm_mode_control
   import irm_pkg::*;
(
   input  wire logic                   MCLK,          // Bus clock
   input  wire logic                   RESET_N,       // Async reset, low
   input  wire logic                   PSEL,          // APB select
   input  wire logic                   PENABLE,       // APB access phase
   input  wire logic                   PWRITE,        // APB write
   input  wire logic [31:0]            PADDR,         // APB byte address
   input  wire logic [IRM_DATA_W-1:0]  PWDATA,        // APB write data
   output logic      [IRM_DATA_W-1:0]  PRDATA,        // APB read data
   output logic                        PREADY,        // APB ready
   output logic                        PSLVERR,       // Unmapped access
   input  wire logic                   PIN_SHARING_SELECT,   // Syscon bit
   input  wire logic                   INFRARED_RECEIVE_PIN, // Rx pin
   output logic                        SHARED_TRANSMIT_PIN,  // Tx pin
   input  wire logic                   COMPANION_UART_TXD,   // UART out
   input  wire logic                   COMPANION_UART_SIR,   // UART IR out
   input  wire logic                   MEDIUM_TX_SERIAL,     // Med shifter
   input  wire logic                   FAST_TX_SERIAL,       // Fast shifter
   input  wire logic                   MEDIUM_TX_BUSY,       // Med busy
   input  wire logic                   FAST_TX_BUSY,         // Fast busy
   output logic                        RX_SERIAL,            // To decoders
   input  wire logic                   ADDR_BYTE_VALID,      // First byte
   input  wire logic [IRM_ADDR_BYTE_W-1:0] ADDR_BYTE,        // Its value
   input  wire logic [IRM_ADDR_BYTE_W-1:0] ADDR_MATCH_VALUE, // Match value
   output logic                        FRAME_ACCEPT,         // Buffer frame
   output logic                        SIR_SELECT,           // Low-rate mode
   output logic                        MEDIUM_SELECT,        // Medium mode
   output logic                        FAST_SELECT,          // Fast mode
   output logic                        RX_LOGIC_ENABLE,      // Rx running
   output logic                        TX_LOGIC_ENABLE,      // Tx running
   output logic                        UNDERRUN_ABORT,       // Abort policy
   output logic                        MEDIUM_RATE_SELECT    // 1.152 Mbit/s
);

   irm_select_t  select_r;
   irm_control_t control_r;
   logic         setup_phase;
   logic         write_access;
   logic         hit_select;
   logic         hit_control;
   logic [IRM_DATA_W-1:0] rdata_nxt;
   logic         ir_mode_active;
   logic         fast_tx_on;
   logic         medium_tx_on;
   logic         loopback_active;
   logic         tx_loop_serial;
   logic         accept_nxt;

   // Register read image, reserved bits as zero
   function automatic logic [IRM_DATA_W-1:0] read_image(
      input irm_select_t  s,
      input irm_control_t c,
      input logic         sel_s,
      input logic         sel_c
   );
      logic [IRM_DATA_W-1:0] v;
      v = '0;
      if (sel_s) begin
         v[IRM_SELECT_W-1:0] = s;
      end else if (sel_c) begin
         v[IRM_CONTROL_W-1:0] = c;
      end
      return v;
   endfunction

   // Mode uses the shared medium/fast datapath
   function automatic logic shared_path(input irm_mode_t m);
      return (m == IRM_MODE_MEDIUM) || (m == IRM_MODE_FAST);
   endfunction

   // Frame address filter: broadcast always passes
   function automatic logic addr_pass(
      input logic                       filter_on,
      input logic [IRM_ADDR_BYTE_W-1:0] addr,
      input logic [IRM_ADDR_BYTE_W-1:0] match
   );
      return !filter_on || (addr == match) ||
             (addr == IRM_BROADCAST_ADDR);
   endfunction

   // Bus decode
   assign setup_phase  = PSEL & ~PENABLE;
   assign write_access = PSEL & PENABLE & PWRITE;
   assign hit_select   = (PADDR == IRM_ADDR_INTERFACE_SELECT);
   assign hit_control  = (PADDR == IRM_ADDR_OPERATING_CONTROL);

   // Interface select register: only mode and loopback are writable.
   // Done bits are forced low while their section transmits and raised
   // only once transmit enable or their mode select is gone and the shifter has gone quiet.
   // One process owns the whole register so it has a single driver.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         select_r <= irm_select_t'(
            IRM_RST_INTERFACE_SELECT[IRM_SELECT_W-1:0]);
      end else begin
         if (write_access && hit_select) begin
            select_r.mode            <= irm_mode_t'(PWDATA[1:0]); // [R4]
            select_r.loopback_select <= PWDATA[2];                // [R10]
         end
         if (fast_tx_on) begin
            select_r.fast_transmit_done <= 1'b0;                  // [R8]
         end else if (!FAST_TX_BUSY) begin
            select_r.fast_transmit_done <= 1'b1;                  // [R6]
         end
         if (medium_tx_on) begin
            select_r.medium_transmit_done <= 1'b0;                // [R8]
         end else if (!MEDIUM_TX_BUSY) begin
            select_r.medium_transmit_done <= 1'b1;                // [R7]
         end
      end
   end

   // Section activity, from the shared control register
   assign ir_mode_active  = shared_path(select_r.mode);           // [R5]
   assign fast_tx_on      = (select_r.mode == IRM_MODE_FAST) &&
                            control_r.transmit_enable;
   assign medium_tx_on    = (select_r.mode == IRM_MODE_MEDIUM) &&
                            control_r.transmit_enable;
   assign loopback_active = select_r.loopback_select && ir_mode_active;

   // Operating control register. Every bit, enables included, is taken
   // at once; clearing the enables before a mode change is software's
   // job, so no interlock stalls a write here. Bit 0 is not stored.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         control_r <= irm_control_t'(
            IRM_RST_OPERATING_CONTROL[IRM_CONTROL_W-1:0]);
      end else if (write_access && hit_control) begin
         control_r          <= irm_control_t'(
            PWDATA[IRM_CONTROL_W-1:0]);                          // [R12]
         control_r.zero_bit <= 1'b0;                             // [R21]
      end
   end

   // Read data and error are prepared in the setup phase so that the
   // access phase answers straight from flip-flops with no wait state
   assign rdata_nxt = read_image(select_r, control_r,
                                 hit_select, hit_control);       // [R21]

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PRDATA <= '0;
      end else if (setup_phase && !PWRITE) begin
         PRDATA <= rdata_nxt;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PSLVERR <= 1'b0;
      end else if (setup_phase) begin
         PSLVERR <= !(hit_select || hit_control);
      end else if (!PSEL) begin
         PSLVERR <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= 1'b1;
      end
   end

   // Mode selects toward the encoders and the companion UART
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SIR_SELECT    <= 1'b0;
         MEDIUM_SELECT <= 1'b0;
         FAST_SELECT   <= 1'b0;
      end else begin
         SIR_SELECT    <= (select_r.mode == IRM_MODE_LOW);       // [R4]
         MEDIUM_SELECT <= (select_r.mode == IRM_MODE_MEDIUM);    // [R4]
         FAST_SELECT   <= (select_r.mode == IRM_MODE_FAST);      // [R4]
      end
   end

   // Direction enables gate the clocks of the shared datapath; a low
   // enable also holds the shifters and buffers cleared
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RX_LOGIC_ENABLE <= 1'b0;
         TX_LOGIC_ENABLE <= 1'b0;
      end else begin
         RX_LOGIC_ENABLE <= control_r.receive_enable &&
                            ir_mode_active;                      // [R16]
         TX_LOGIC_ENABLE <= control_r.transmit_enable &&
                            ir_mode_active;                      // [R17]
      end
   end

   // Policies passed to the shared encoder
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         UNDERRUN_ABORT     <= 1'b0;
         MEDIUM_RATE_SELECT <= 1'b0;
      end else begin
         UNDERRUN_ABORT     <= control_r.underrun_policy_select; // [R18]
         MEDIUM_RATE_SELECT <= control_r.medium_rate_select;     // [R19]
      end
   end

   // Address filter: decided on the first byte, held for the frame
   assign accept_nxt = addr_pass(control_r.address_filter_enable,
                                 ADDR_BYTE, ADDR_MATCH_VALUE);

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FRAME_ACCEPT <= 1'b0;
      end else if (ADDR_BYTE_VALID) begin
         FRAME_ACCEPT <= accept_nxt;                             // [R13]
      end
   end

   // Loopback taps the raw shifter of whichever section is selected
   assign tx_loop_serial = (select_r.mode == IRM_MODE_FAST) ?
                           FAST_TX_SERIAL : MEDIUM_TX_SERIAL;

   irm_rx_path u_rx_path (
      .clk       (MCLK),
      .rst_n     (RESET_N),
      .pin       (INFRARED_RECEIVE_PIN),                         // [R2]
      .invert    (control_r.receive_invert),                     // [R14]
      .loopback  (loopback_active),                              // [R10]
      .tx_serial (tx_loop_serial),
      .rx_serial (RX_SERIAL)
   );

   // The pin sharing bit is owned by system configuration; software is
   // trusted to set it for every infrared mode
   irm_tx_path u_tx_path (
      .clk        (MCLK),
      .rst_n      (RESET_N),
      .mode       (select_r.mode),
      .tx_enable  (control_r.transmit_enable && ir_mode_active), // [R17]
      .invert     (control_r.transmit_invert),                   // [R15]
      .medium_ser (MEDIUM_TX_SERIAL),
      .fast_ser   (FAST_TX_SERIAL),
      .uart_txd   (COMPANION_UART_TXD),
      .uart_sir   (COMPANION_UART_SIR),
      .sharing    (PIN_SHARING_SELECT),                          // [R3]
      .pin        (SHARED_TRANSMIT_PIN)                          // [R1]
   );

endmodule // irm_mode_control

// File: verilog/irm_pkg.sv
/*
 * Shared constants and types of the infrared mode control block: register
 * addresses, reset values, field widths, mode codes and the packed layouts
 * of the two registers.
 * Assumes a 32-bit peripheral bus with byte addresses.
 */
package irm_pkg;

   localparam int IRM_DATA_W   = 32;
   localparam int IRM_SELECT_W = 5;
   localparam int IRM_CONTROL_W = 8;
   localparam int IRM_ADDR_BYTE_W = 8;

   localparam logic [31:0] IRM_ADDR_INTERFACE_SELECT  = 32'h808b0000;
   localparam logic [31:0] IRM_ADDR_OPERATING_CONTROL = 32'h808b0004;

   localparam logic [31:0] IRM_RST_INTERFACE_SELECT  = 32'h00000018;
   localparam logic [31:0] IRM_RST_OPERATING_CONTROL = 32'h00000000;

   // Address value that every receiver accepts
   localparam logic [7:0]  IRM_BROADCAST_ADDR = 8'hff;

   // Interface modes, in field order 00, 01, 10, 11
   typedef enum logic [1:0] {
      IRM_MODE_NONE,
      IRM_MODE_LOW,
      IRM_MODE_MEDIUM,
      IRM_MODE_FAST
   } irm_mode_t;

   // Interface select register, bits 4..0
   typedef struct packed {
      logic      fast_transmit_done;
      logic      medium_transmit_done;
      logic      loopback_select;
      irm_mode_t mode;
   } irm_select_t;

   // Operating control register, bits 7..0
   typedef struct packed {
      logic address_filter_enable;
      logic receive_invert;
      logic transmit_invert;
      logic receive_enable;
      logic transmit_enable;
      logic underrun_policy_select;
      logic medium_rate_select;
      logic zero_bit;
   } irm_control_t;

endpackage

// File: verilog/irm_rx_path.sv
/*
 * Receive input conditioning: synchronises the receive pin, applies the
 * receive polarity and substitutes the transmit shifter in loopback.
 * Assumes the pin is asynchronous to the clock; tx_serial is on the clock.
 */
`timescale 1ns/1ps
module irm_rx_path
   import irm_pkg::*;
(
   input  wire logic clk,         // Block clock
   input  wire logic rst_n,       // Async reset, low
   input  wire logic pin,         // Receive pin, asynchronous
   input  wire logic invert,      // Receive polarity
   input  wire logic loopback,    // Loopback active
   input  wire logic tx_serial,   // Transmit shifter output
   output logic      rx_serial    // Serial to the decoders
);

   logic sync1_r;
   logic sync2_r;
   logic rx_nxt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin;                                   // [R2]
         sync2_r <= sync1_r;
      end
   end

   always_comb begin
      // Loopback bypasses the pin, so no polarity is applied to it
      if (loopback) begin
         rx_nxt = tx_serial;                               // [R10]
      end else begin
         rx_nxt = sync2_r ^ invert;                        // [R14]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_serial <= 1'b0;
      end else begin
         rx_serial <= rx_nxt;
      end
   end

endmodule // irm_rx_path

// File: verilog/irm_tx_path.sv
/*
 * Transmit pin driver: picks the active encoder output, applies the
 * transmit polarity and shares the pin with the companion UART.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module irm_tx_path
   import irm_pkg::*;
(
   input  wire logic      clk,          // Block clock
   input  wire logic      rst_n,        // Async reset, low
   input  wire irm_mode_t mode,         // Selected interface
   input  wire logic      tx_enable,    // Transmit logic running
   input  wire logic      invert,       // Transmit polarity
   input  wire logic      medium_ser,   // Medium-rate encoder output
   input  wire logic      fast_ser,     // Fast-rate encoder output
   input  wire logic      uart_txd,     // Companion UART plain output
   input  wire logic      uart_sir,     // Companion UART infrared output
   input  wire logic      sharing,      // Pin sharing select
   output logic           pin           // Shared transmit pin
);

   logic raw;
   logic ir_out;
   logic pin_nxt;

   always_comb begin
      raw = (mode == IRM_MODE_FAST) ? fast_ser : medium_ser;
      // Disabled transmitter stays quiet so it cannot mask the UART
      ir_out = tx_enable & (raw ^ invert);                 // [R15]
      if (sharing) begin
         pin_nxt = ir_out | uart_sir;                      // [R1]
      end else begin
         pin_nxt = uart_txd;                               // [R1]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin <= 1'b0;
      end else begin
         pin <= pin_nxt;
      end
   end

endmodule // irm_tx_path

// File: bench/irm_ir_link_model.sv
/*
 * Infrared transceiver model on the serial pins: drives the receive pin
 * and registers what the block puts on the transmit pin.
 * Assumes the bench clock; the pin is sampled by the block as async.
 */
`timescale 1ns/1ps
module irm_ir_link_model (
   input  wire logic clk,        // Bench clock
   input  wire logic drive_en,   // Optical signal present
   input  wire logic drive_bit,  // Level to present
   input  wire logic tx_pin,     // Block transmit pin
   output logic      rx_pin,     // Block receive pin
   output logic      tx_seen     // Last transmit level observed
);
   initial rx_pin = 1'b0;
   initial tx_seen = 1'b0;
   // No light on the optics: toggle so a stale level never passes
   always @(posedge clk) begin
      rx_pin <= drive_en ? drive_bit : ~rx_pin;
      tx_seen <= tx_pin;
   end
endmodule // irm_ir_link_model

// File: bench/irm_mode_control_monitor.sv
/*
 * Port checker of the infrared mode control block, bound to its top.
 * Assumes one clock domain, MCLK, and the async low reset RESET_N.
 */
`timescale 1ns/1ps
module irm_mode_control_monitor
   import irm_pkg::*;
(
   input wire logic        MCLK,                // Clock
   input wire logic        RESET_N,             // Reset
   input wire logic        PSEL,                // Select
   input wire logic        PENABLE,             // Access
   input wire logic        PWRITE,              // Write
   input wire logic [31:0] PADDR,               // Address
   input wire logic [31:0] PWDATA,              // Write data
   input wire logic [31:0] PRDATA,              // Read data
   input wire logic        PSLVERR,             // Error
   input wire logic        PIN_SHARING_SELECT,  // Sharing
   input wire logic        COMPANION_UART_TXD,  // UART out
   input wire logic        COMPANION_UART_SIR,  // UART IR out
   input wire logic        SHARED_TRANSMIT_PIN, // Tx pin
   input wire logic        ADDR_BYTE_VALID,     // Address strobe
   input wire logic [7:0]  ADDR_BYTE,           // Address
   input wire logic        FRAME_ACCEPT,        // Accept
   input wire logic        MEDIUM_SELECT,       // Medium
   input wire logic        FAST_SELECT,         // Fast
   input wire logic        TX_LOGIC_ENABLE,     // Tx running
   input wire logic        UNDERRUN_ABORT,      // Policy
   input wire logic        MEDIUM_RATE_SELECT   // Rate
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   sequence ctl_access;
      PSEL && PENABLE && PWRITE && PADDR == IRM_ADDR_OPERATING_CONTROL;
   endsequence
   sequence mapped_read;
      PSEL && !PENABLE && !PWRITE && (PADDR == IRM_ADDR_INTERFACE_SELECT
         || PADDR == IRM_ADDR_OPERATING_CONTROL);
   endsequence

   a_uart_only_pin: assert property (!PIN_SHARING_SELECT |=>
      SHARED_TRANSMIT_PIN == $past(COMPANION_UART_TXD))
      else $error("transmit pin not the plain UART output");
   a_sir_or_pin: assert property (PIN_SHARING_SELECT &&
      COMPANION_UART_SIR |=> SHARED_TRANSMIT_PIN)
      else $error("transmit pin lost the UART infrared output");
   a_broadcast_accept: assert property (ADDR_BYTE_VALID &&
      ADDR_BYTE == IRM_BROADCAST_ADDR |=> FRAME_ACCEPT)
      else $error("broadcast frame refused");
   a_accept_held: assert property (!ADDR_BYTE_VALID |=>
      $stable(FRAME_ACCEPT))
      else $error("frame accept moved without an address");
   a_mode_exclusive: assert property (!(MEDIUM_SELECT && FAST_SELECT))
      else $error("two modes selected at once");
   a_tx_needs_mode: assert property (TX_LOGIC_ENABLE |->
      MEDIUM_SELECT || FAST_SELECT)
      else $error("transmit running without a medium or fast mode");
   a_unmapped_error: assert property (PSEL && !PENABLE &&
      PADDR != IRM_ADDR_INTERFACE_SELECT &&
      PADDR != IRM_ADDR_OPERATING_CONTROL |=> PSLVERR &&
      ($past(PWRITE) || PRDATA == 32'h0)) // Writes leave read data as is
      else $error("unmapped access not refused");
   a_underrun_follow: assert property (ctl_access |-> ##2
      UNDERRUN_ABORT == $past(PWDATA[2], 2))
      else $error("underrun policy not taken from the write");
   a_rate_follow: assert property (ctl_access |-> ##2
      MEDIUM_RATE_SELECT == $past(PWDATA[1], 2))
      else $error("medium rate not taken from the write");
   a_reserved_zero: assert property (mapped_read |=>
      PRDATA[31:8] == 24'h0)
      else $error("reserved bits read nonzero");
endmodule // irm_mode_control_monitor

bind irm_mode_control irm_mode_control_monitor u_mon (
   .MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR), .PIN_SHARING_SELECT(PIN_SHARING_SELECT),
   .COMPANION_UART_TXD(COMPANION_UART_TXD),
   .COMPANION_UART_SIR(COMPANION_UART_SIR),
   .SHARED_TRANSMIT_PIN(SHARED_TRANSMIT_PIN),
   .ADDR_BYTE_VALID(ADDR_BYTE_VALID), .ADDR_BYTE(ADDR_BYTE),
   .FRAME_ACCEPT(FRAME_ACCEPT), .MEDIUM_SELECT(MEDIUM_SELECT),
   .FAST_SELECT(FAST_SELECT), .TX_LOGIC_ENABLE(TX_LOGIC_ENABLE),
   .UNDERRUN_ABORT(UNDERRUN_ABORT), .MEDIUM_RATE_SELECT(MEDIUM_RATE_SELECT));

// File: bench/test_infrared_mode_control.sv
/*
 * Self-checking bench of the infrared mode control block: register
 * accesses on the peripheral bus, done status, pins and address filter.
 * Assumes a zero-wait bus slave and the transceiver model on the pins.
 */
`timescale 1ns/1ps
module test_infrared_mode_control
   import irm_pkg::*;
;
   localparam logic [31:0] SEL = IRM_ADDR_INTERFACE_SELECT;
   localparam logic [31:0] CTL = IRM_ADDR_OPERATING_CONTROL;
   logic        MCLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, q;
   logic        PREADY, PSLVERR, SHARE = 0, RECEIVE_INVERT, TRANSMIT_INVERT, UTXD = 0, USIR = 0;
   logic        MSER = 0, FSER = 0, MBSY = 0, FBSY = 0, RXS, AV = 0, ACC;
   logic [7:0]  AB = 0, AM = 0;
   logic        SIR, MED, FST, RXEN, TXEN, UABT, MRATE, e, den = 0, dbit = 0;
   logic        seen;
   int          bad_count = 0, cmp_count = 0;

   always #2 MCLK = ~MCLK;

   irm_mode_control DUT (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PIN_SHARING_SELECT(SHARE), .INFRARED_RECEIVE_PIN(RECEIVE_INVERT),
      .SHARED_TRANSMIT_PIN(TRANSMIT_INVERT), .COMPANION_UART_TXD(UTXD),
      .COMPANION_UART_SIR(USIR), .MEDIUM_TX_SERIAL(MSER),
      .FAST_TX_SERIAL(FSER), .MEDIUM_TX_BUSY(MBSY), .FAST_TX_BUSY(FBSY),
      .RX_SERIAL(RXS), .ADDR_BYTE_VALID(AV), .ADDR_BYTE(AB),
      .ADDR_MATCH_VALUE(AM), .FRAME_ACCEPT(ACC), .SIR_SELECT(SIR),
      .MEDIUM_SELECT(MED), .FAST_SELECT(FST), .RX_LOGIC_ENABLE(RXEN),
      .TX_LOGIC_ENABLE(TXEN), .UNDERRUN_ABORT(UABT),
      .MEDIUM_RATE_SELECT(MRATE));

   irm_ir_link_model u_link (.clk(MCLK), .drive_en(den), .drive_bit(dbit),
      .tx_pin(TRANSMIT_INVERT), .rx_pin(RECEIVE_INVERT), .tx_seen(seen));

   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] x, g);
      cmp_count++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", n, x, g);
         bad_count++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask

   // Zero-wait slave, but the ready wait is still bounded
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      @(posedge MCLK);
      #1 {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {2'b10, w, a, d};
      @(posedge MCLK);
      #1 PENABLE = 1;
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 8);
      q = PRDATA;
      e = PSLVERR;
      if (PREADY !== 1'b1) begin
         bad_count++;
         results();
      end
      #1 {PSEL, PENABLE} = 2'b00;
      cyc(2);
   endtask

   task automatic addr(input logic [7:0] b, input logic x);
      @(posedge MCLK);
      #1 {AV, AB} = {1'b1, b};
      @(posedge MCLK);
      #1 AV = 0;
      chk("frame accept", x, ACC);
   endtask

   initial begin
      cyc(6);
      RESET_N = 1;
      cyc(2);
      apb(0, SEL, 0); chk("select reset", IRM_RST_INTERFACE_SELECT, q);
      apb(0, CTL, 0); chk("control reset", IRM_RST_OPERATING_CONTROL, q);
      SHARE = 1;
      apb(1, CTL, 32'hfffffffe);
      apb(0, CTL, 0); chk("control mask", 32'hfe, q);
      apb(1, CTL, 0);
      apb(1, SEL, 32'hffffffe7);
      apb(0, SEL, 0); chk("select mask", 32'h1f, q);
      for (int m = 0; m < 4; m++) begin
         apb(1, SEL, m);
         chk("mode", (m == 0) ? 3'b000 : 3'b100 >> (m - 1), {SIR, MED, FST});
      end
      apb(1, SEL, 2);
      MBSY = 1;
      apb(1, CTL, 32'h18);
      chk("enables", 2'b11, {RXEN, TXEN});
      apb(0, SEL, 0); chk("medium busy", 32'h12, q);
      apb(1, CTL, 32'h10);
      apb(0, SEL, 0); chk("medium held", 32'h12, q);
      MBSY = 0;
      cyc(2);
      apb(0, SEL, 0); chk("medium done", 32'h1a, q);
      chk("tx stopped", 0, TXEN);
      apb(1, CTL, 0);
      apb(1, SEL, 3);
      apb(1, CTL, 32'h08);
      apb(0, SEL, 0); chk("fast busy", 32'h0b, q);
      apb(0, CTL, 0); chk("shared control", 32'h08, q);
      chk("pin plain", 0, TRANSMIT_INVERT);
      apb(1, CTL, 32'h28);
      chk("pin inverted", 1, TRANSMIT_INVERT);
      FSER = 1;
      cyc(2);
      chk("pin inverted one", 0, TRANSMIT_INVERT);
      USIR = 1;
      cyc(2);
      chk("pin or", 1, TRANSMIT_INVERT);
      chk("link sees pin", 1, seen);
      SHARE = 0;
      cyc(2);
      chk("pin uart", 0, TRANSMIT_INVERT);
      {SHARE, USIR} = 2'b10;
      apb(1, CTL, 0);
      apb(0, SEL, 0); chk("fast done", 32'h1b, q);
      apb(1, SEL, 32'h6);
      apb(1, CTL, 32'h18);
      {den, dbit, MSER} = 3'b101;
      cyc(3);
      chk("loopback", 1, RXS);
      MSER = 0;
      cyc(3);
      chk("loopback zero", 0, RXS);
      apb(1, CTL, 0);
      apb(1, SEL, 32'h2);
      apb(1, CTL, 32'h10);
      dbit = 1;
      cyc(6);
      chk("rx pin", 1, RXS);
      apb(1, CTL, 32'h50);
      cyc(4);
      chk("rx inverted", 0, RXS);
      apb(1, CTL, 0);
      apb(1, SEL, 32'h5);
      cyc(4);
      chk("rx low mode", 1, RXS);
      apb(1, CTL, 32'h80);
      AM = 8'h5a;
      addr(8'h5a, 1);
      addr(8'h3c, 0);
      addr(8'hff, 1);
      apb(1, CTL, 0);
      addr(8'h3c, 1);
      for (int i = 0; i < 4; i++) begin
         apb(1, CTL, i << 1);
         chk("underrun rate", i, {UABT, MRATE});
      end
      apb(1, SEL + 32'h8, 32'h3);
      chk("unmapped error", 1, e);
      apb(0, SEL + 32'h8, 0); chk("unmapped data", 0, q);
      apb(0, SEL, 0); chk("select kept", 32'h1d, q);
      results();
   end
endmodule // test_infrared_mode_control
